// [logic/bus_ctl_defs.vh]
// constants shared by the minimum-mode bus control logic
`ifndef BUS_CTL_DEFS_VH
`define BUS_CTL_DEFS_VH

// ****************************************************************
// bus cycle kinds
// ****************************************************************
`define KIND_W        3
`define KIND_MEM_RD   3'h0
`define KIND_MEM_WR   3'h1
`define KIND_IO_RD    3'h2
`define KIND_IO_WR    3'h3
`define KIND_INT_ACK  3'h4

// ****************************************************************
// timing and vectors
// ****************************************************************
`define HALF_FIRST    1'h0
`define HALF_SECOND   1'h1
`define NMI_TYPE      8'h02
`define SYNC_W        4
`define SYNC_NMI      0
`define SYNC_RESET    1
`define SYNC_HOLD     2
`define SYNC_READY    3

`endif

// [logic/two_flop_sync.v]
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module two_flop_sync #(
    parameter WIDTH = 1
) (
    input  wire             core_clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] first_reg;
    reg [WIDTH-1:0] second_reg;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            first_reg  <= {WIDTH{1'b0}};
            second_reg <= {WIDTH{1'b0}};
        end else begin
            first_reg  <= async_in;
            second_reg <= first_reg;
        end
    end

    assign sync_out = second_reg;
endmodule // two_flop_sync
`default_nettype wire

// [logic/cpu_min_mode_bus_control.v]
// minimum-mode bus strobe, nmi, reset and hold control
`timescale 1ns/1ps
`default_nettype none
`include "bus_ctl_defs.vh"
module cpu_min_mode_bus_control (
    input  wire                 core_clk,
    input  wire                 rst_b,
    input  wire                 reset_pin,
    input  wire                 nmi_pin,
    input  wire                 hold_request,
    input  wire                 bus_ready,
    input  wire                 min_max_mode_strap,
    input  wire                 req_valid,
    input  wire [`KIND_W-1:0]   req_kind,
    output wire                 req_ready,
    input  wire                 instr_done,
    output reg                  cycle_done,
    output reg                  nmi_take,
    output reg  [7:0]           nmi_vector_type,
    output reg                  restart,
    output wire                 core_in_reset,
    output reg                  hold_grant,
    output reg                  addr_latch_strobe,
    output reg                  io_mem_select,
    output wire                 io_mem_select_oe_n,
    output reg                  write_strobe_n,
    output wire                 write_strobe_oe_n,
    output reg                  interrupt_ack_strobe_n,
    output reg                  transfer_direction,
    output wire                 transfer_direction_oe_n,
    output reg                  transceiver_output_enable_n,
    output wire                 transceiver_output_enable_oe_n
);

    // ************************************************************
    // state encoding
    // ************************************************************
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_PRE  = 3'h1;
    localparam [2:0] ST_T1   = 3'h2;
    localparam [2:0] ST_T2   = 3'h3;
    localparam [2:0] ST_T3   = 3'h4;
    localparam [2:0] ST_TW   = 3'h5;
    localparam [2:0] ST_T4   = 3'h6;
    localparam [2:0] ST_HOLD = 3'h7;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function is_write;
        input [`KIND_W-1:0] k;
        begin
            is_write = (k == `KIND_MEM_WR) || (k == `KIND_IO_WR);
        end
    endfunction

    function is_io;
        input [`KIND_W-1:0] k;
        begin
            is_io = (k == `KIND_IO_RD) || (k == `KIND_IO_WR);
        end
    endfunction

    function is_int_ack;
        input [`KIND_W-1:0] k;
        begin
            is_int_ack = (k == `KIND_INT_ACK);
        end
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    wire [`SYNC_W-1:0] pins_sync;
    wire               nmi_s;
    wire               reset_s;
    wire               hold_s;
    wire               ready_s;

    two_flop_sync #(
        .WIDTH (`SYNC_W)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in ({bus_ready, hold_request, reset_pin, nmi_pin}),
        .sync_out (pins_sync)
    );

    assign nmi_s   = pins_sync[`SYNC_NMI];
    assign reset_s = pins_sync[`SYNC_RESET];
    assign hold_s  = pins_sync[`SYNC_HOLD];
    assign ready_s = pins_sync[`SYNC_READY];

    // the strap is static: caught by two clocked stages after release
    reg strap_meta_reg;
    reg min_mode_reg;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            strap_meta_reg <= 1'b1;
            min_mode_reg   <= 1'b1;
        end else begin
            strap_meta_reg <= min_max_mode_strap;
            min_mode_reg   <= strap_meta_reg;
        end
    end

    // ************************************************************
    // reset pin and restart
    // ************************************************************
    reg reset_prev_reg;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            reset_prev_reg <= 1'b0;
            restart        <= 1'b0;
        end else begin
            reset_prev_reg <= reset_s;
            restart        <= reset_prev_reg && !reset_s;
        end
    end

    assign core_in_reset = reset_s;

    // ************************************************************
    // non-maskable interrupt
    // ************************************************************
    // no mask input exists, every rising edge outside reset is kept pending
    reg  nmi_prev_reg;
    reg  nmi_pend_reg;
    wire nmi_rise;
    wire nmi_fire;

    assign nmi_rise = nmi_s && !nmi_prev_reg;
    assign nmi_fire = nmi_pend_reg && instr_done && !reset_s;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            nmi_prev_reg    <= 1'b0;
            nmi_pend_reg    <= 1'b0;
            nmi_take        <= 1'b0;
            nmi_vector_type <= 8'h00;
        end else begin
            nmi_prev_reg <= nmi_s;
            if (reset_s) begin
                nmi_pend_reg <= 1'b0;
            end else if (nmi_rise) begin
                // a new edge wins over the take in the same cycle
                nmi_pend_reg <= 1'b1;
            end else if (nmi_fire) begin
                nmi_pend_reg <= 1'b0;
            end
            nmi_take        <= nmi_fire;
            nmi_vector_type <= `NMI_TYPE;
        end
    end

    // ************************************************************
    // bus cycle sequencer
    // ************************************************************
    reg  [2:0]         state_reg;
    reg  [2:0]         state_next;
    reg                half_reg;
    reg                half_next;
    reg  [`KIND_W-1:0] kind_reg;
    reg                float_reg;
    reg                float_next;
    reg                done_next;
    wire               accept;

    assign req_ready = (state_reg == ST_IDLE) && !reset_s && !hold_s;
    assign accept    = req_valid && req_ready;

    always @* begin
        state_next = state_reg;
        half_next  = ~half_reg;
        float_next = float_reg;
        done_next  = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                half_next = `HALF_FIRST;
                if (hold_s) begin
                    state_next = ST_HOLD;
                    float_next = 1'b1;
                end else if (accept) begin
                    state_next = ST_PRE;
                    float_next = 1'b0;
                end
            end
            ST_PRE: begin
                if (half_reg == `HALF_SECOND) begin
                    state_next = ST_T1;
                end
            end
            ST_T1: begin
                if (half_reg == `HALF_SECOND) begin
                    state_next = ST_T2;
                end
            end
            ST_T2: begin
                if (half_reg == `HALF_SECOND) begin
                    state_next = ST_T3;
                end
            end
            ST_T3, ST_TW: begin
                if (half_reg == `HALF_SECOND) begin
                    state_next = ready_s ? ST_T4 : ST_TW;
                end
            end
            ST_T4: begin
                if (half_reg == `HALF_SECOND) begin
                    state_next = ST_IDLE;
                    done_next  = 1'b1;
                end
            end
            ST_HOLD: begin
                half_next = `HALF_FIRST;
                if (!hold_s) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                half_next  = `HALF_FIRST;
            end
        endcase
        if (reset_s) begin
            state_next = ST_IDLE;
            half_next  = `HALF_FIRST;
            done_next  = 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg  <= ST_IDLE;
            half_reg   <= `HALF_FIRST;
            kind_reg   <= `KIND_MEM_RD;
            float_reg  <= 1'b0;
            hold_grant <= 1'b0;
            cycle_done <= 1'b0;
        end else begin
            state_reg  <= state_next;
            half_reg   <= half_next;
            float_reg  <= float_next;
            hold_grant <= (state_next == ST_HOLD);
            cycle_done <= done_next;
            if (accept) begin
                kind_reg <= req_kind;
            end
        end
    end

    // ************************************************************
    // strobe generation
    // ************************************************************
    reg  ale_next;
    reg  iom_next;
    reg  dir_next;
    reg  wr_n_next;
    reg  interrupt_ack_strobe_n_n_next;
    reg  den_n_next;
    reg  in_cycle;
    reg  data_phase;
    reg  [`KIND_W-1:0] k;
    reg  float_pins_reg;

    always @* begin
        k          = accept ? req_kind : kind_reg;
        in_cycle   = (state_next != ST_IDLE) && (state_next != ST_HOLD);
        data_phase = (state_next == ST_T2) || (state_next == ST_T3) ||
                     (state_next == ST_TW);
        ale_next   = (state_next == ST_T1) &&
                     (half_next == `HALF_SECOND);
        iom_next   = in_cycle ? is_io(k) : io_mem_select;
        dir_next   = in_cycle ? is_write(k) : transfer_direction;
        wr_n_next  = !(data_phase && is_write(k));
        interrupt_ack_strobe_n_n_next = !(data_phase && is_int_ack(k));
        if (is_write(k)) begin
            den_n_next = !(data_phase ||
                           ((state_next == ST_T4) &&
                            (half_next == `HALF_FIRST)));
        end else begin
            den_n_next = !(((state_next == ST_T2) &&
                            (half_next == `HALF_SECOND)) ||
                           (state_next == ST_T3) ||
                           (state_next == ST_TW) ||
                           ((state_next == ST_T4) &&
                            (half_next == `HALF_FIRST)));
        end
        if (reset_s) begin
            den_n_next  = 1'b1;
            wr_n_next   = 1'b1;
            interrupt_ack_strobe_n_n_next = 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            addr_latch_strobe           <= 1'b0;
            io_mem_select               <= 1'b0;
            transfer_direction          <= 1'b0;
            write_strobe_n              <= 1'b1;
            interrupt_ack_strobe_n      <= 1'b1;
            transceiver_output_enable_n <= 1'b1;
            float_pins_reg              <= 1'b0;
        end else begin
            addr_latch_strobe           <= ale_next;
            io_mem_select               <= iom_next;
            transfer_direction          <= dir_next;
            write_strobe_n              <= wr_n_next;
            interrupt_ack_strobe_n      <= interrupt_ack_strobe_n_n_next;
            transceiver_output_enable_n <= den_n_next;
            float_pins_reg <= float_next || !min_mode_reg;
        end
    end

    // ************************************************************
    // pin drivers: enable low while driving
    // ************************************************************
    assign io_mem_select_oe_n             = float_pins_reg;
    assign write_strobe_oe_n              = float_pins_reg;
    assign transfer_direction_oe_n        = float_pins_reg;
    assign transceiver_output_enable_oe_n = float_pins_reg;

endmodule // cpu_min_mode_bus_control
`default_nettype wire

// [verif/bus_ctl_sva.sv]
// concurrent checks on the minimum-mode bus control ports
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_sva (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       instr_done,
    input wire logic       cycle_done,
    input wire logic       nmi_take,
    input wire logic [7:0] nmi_vector_type,
    input wire logic       restart,
    input wire logic       core_in_reset,
    input wire logic       hold_grant,
    input wire logic       addr_latch_strobe,
    input wire logic       io_mem_select,
    input wire logic       io_mem_select_oe_n,
    input wire logic       write_strobe_n,
    input wire logic       write_strobe_oe_n,
    input wire logic       interrupt_ack_strobe_n,
    input wire logic       transfer_direction,
    input wire logic       transfer_direction_oe_n,
    input wire logic       transceiver_output_enable_n,
    input wire logic       transceiver_output_enable_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_ale_pulse: assert property (addr_latch_strobe |=> !addr_latch_strobe)
        else $error("address latch strobe longer than one cycle");
    a_write_len: assert property (addr_latch_strobe && transfer_direction |=>
        !write_strobe_n [*4]) else $error("write strobe too short");
    a_interrupt_ack_strobe_n_len: assert property ($fell(interrupt_ack_strobe_n) |->
        !interrupt_ack_strobe_n [*4]) else $error("interrupt_ack_strobe_n strobe too short");
    a_read_den: assert property (addr_latch_strobe && !transfer_direction |=>
        transceiver_output_enable_n ##1 !transceiver_output_enable_n)
        else $error("read enable not at mid T2");
    a_den_end: assert property (cycle_done |->
        $past(transceiver_output_enable_n) && !$past(transceiver_output_enable_n, 2))
        else $error("enable not released at mid T4");
    a_write_den: assert property ($fell(write_strobe_n) |->
        !transceiver_output_enable_n && transfer_direction)
        else $error("write enable or direction wrong at T2");
    a_hold_float: assert property (hold_grant |-> io_mem_select_oe_n &&
        write_strobe_oe_n && transfer_direction_oe_n &&
        transceiver_output_enable_oe_n) else $error("output driven in hold");
    a_select_stable: assert property (addr_latch_strobe |=>
        $stable(io_mem_select) [*6]) else $error("select changed in cycle");
    a_nmi_vector: assert property (nmi_take |->
        nmi_vector_type == 8'h02 && $past(instr_done))
        else $error("nmi taken wrongly");
    a_reset_abort: assert property (core_in_reset && $past(core_in_reset) |->
        write_strobe_n && interrupt_ack_strobe_n && transceiver_output_enable_n)
        else $error("strobe active in reset");
    a_restart_fall: assert property (restart |-> !core_in_reset &&
        ($past(core_in_reset, 2) || $past(core_in_reset, 3)))
        else $error("restart without reset fall");

    c_write: cover property ($fell(write_strobe_n));
    c_nmi: cover property (nmi_take);
    c_hold: cover property (hold_grant);
    c_restart: cover property (restart);
endmodule // bus_ctl_sva
`default_nettype wire

// [verif/bus_partner_model.sv]
// far-side memory and io device that stretches cycles with wait states
`timescale 1ns/1ps
`default_nettype none
module bus_partner_model (
    input  wire logic       core_clk,
    input  wire logic       addr_latch_strobe,
    input  wire logic [3:0] stall_cycles,
    output wire logic       bus_ready
);
    logic [3:0] wait_reg = 4'h0;
    // not ready for stall_cycles clocks after the address phase
    always @(posedge core_clk) begin
        if (addr_latch_strobe) begin
            wait_reg <= stall_cycles;
        end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
        end
    end
    assign bus_ready = (wait_reg == 4'h0);
endmodule // bus_partner_model
`default_nettype wire

// [verif/tb.sv]
// self-checking testbench for the minimum-mode bus control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       core_clk, rst_b, reset_pin, nmi_pin, hold_request;
    logic       min_max_mode_strap, req_valid, instr_done, sel, dir;
    logic [2:0] req_kind;
    logic [3:0] stall_cycles;
    logic [7:0] lat, wr_lo, ia_lo, den_lo, al_n, n;
    wire        bus_ready, req_ready, cycle_done, nmi_take, restart;
    wire        core_in_reset, hold_grant, addr_latch_strobe;
    wire        io_mem_select, io_mem_select_oe_n, write_strobe_n;
    wire        write_strobe_oe_n, interrupt_ack_strobe_n, transfer_direction;
    wire        transfer_direction_oe_n, transceiver_output_enable_n;
    wire        transceiver_output_enable_oe_n;
    wire [7:0]  nmi_vector_type;
    wire [7:0]  oe_all;
    int         mismatches, check_count, cyc = 0;

    assign oe_all = {4'h0, io_mem_select_oe_n, write_strobe_oe_n,
                     transfer_direction_oe_n, transceiver_output_enable_oe_n};

    cpu_min_mode_bus_control cpu_min_mode_bus_control_inst (
        .core_clk, .rst_b, .reset_pin, .nmi_pin, .hold_request, .bus_ready,
        .min_max_mode_strap, .req_valid, .req_kind, .req_ready, .instr_done,
        .cycle_done, .nmi_take, .nmi_vector_type, .restart, .core_in_reset,
        .hold_grant, .addr_latch_strobe, .io_mem_select, .io_mem_select_oe_n,
        .write_strobe_n, .write_strobe_oe_n, .interrupt_ack_strobe_n,
        .transfer_direction, .transfer_direction_oe_n,
        .transceiver_output_enable_n, .transceiver_output_enable_oe_n
    );
    bus_partner_model bus_partner_model_inst (
        .core_clk, .addr_latch_strobe, .stall_cycles, .bus_ready
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk; // two clocks per T-state
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches = mismatches + 1;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ************************************************************
    // one bus cycle, counting strobe cycles until done
    // ************************************************************
    task automatic run_cycle(input logic [2:0] kind);
        @(negedge core_clk);
        req_valid = 1'b1;
        req_kind = kind;
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        {lat, wr_lo, ia_lo, den_lo, al_n} = {8'h01, 32'h0};
        repeat (40) begin
            @(negedge core_clk);
            lat++;
            if (write_strobe_n === 1'b0) wr_lo++;
            if (interrupt_ack_strobe_n === 1'b0) ia_lo++;
            if (transceiver_output_enable_n === 1'b0) den_lo++;
            if (addr_latch_strobe === 1'b1) begin
                al_n++;
                sel = io_mem_select;
                dir = transfer_direction;
            end
            if (cycle_done === 1'b1) break;
        end
    endtask

    task automatic t_kinds();
        logic wr;
        for (int k = 0; k < 5; k++) begin
            wr = (k == 1 || k == 3);
            run_cycle(3'(k));
            check("latency", 8'h0B, lat);
            check("ale pulses", 8'h01, al_n);
            check("select", {7'h00, k == 2 || k == 3}, {7'h00, sel});
            check("direction", {7'h00, wr}, {7'h00, dir});
            check("write low", wr ? 8'h04 : 8'h00, wr_lo);
            check("interrupt_ack_strobe_n low", k == 4 ? 8'h04 : 8'h00, ia_lo);
            check("enable low", wr ? 8'h05 : 8'h04, den_lo);
        end
        stall_cycles = 4'h6;
        run_cycle(3'h1);
        stall_cycles = 4'h0;
        check("write stretched", 8'h01, {7'h00, wr_lo > 8'h04 && !wr_lo[0]});
        check("wait latency", wr_lo + 8'h07, lat);
        $display("test kinds and waits done");
    endtask

    task automatic t_nmi();
        repeat (2) begin
            nmi_pin = 1'b0;
            repeat (4) @(negedge core_clk);
            nmi_pin = 1'b1;
            n = 8'h00;
            repeat (8) begin
                @(negedge core_clk);
                if (nmi_take !== 1'b0) n++;
            end
            check("take before end", 8'h00, n);
            instr_done = 1'b1;
            @(negedge core_clk);
            check("take", 8'h01, {7'h00, nmi_take});
            check("vector type", 8'h02, nmi_vector_type);
            instr_done = 1'b0;
            @(negedge core_clk);
            check("take once", 8'h00, {7'h00, nmi_take});
        end
        nmi_pin = 1'b0;
        $display("test nmi done");
    endtask

    task automatic t_hold();
        hold_request = 1'b1;
        repeat (3) @(negedge core_clk);
        check("grant", 8'h01, {7'h00, hold_grant});
        check("floated", 8'h0F, oe_all);
        check("refused", 8'h00, {7'h00, req_ready});
        hold_request = 1'b0;
        repeat (3) @(negedge core_clk);
        check("grant drop", 8'h00, {7'h00, hold_grant});
        check("still floated", 8'h0F, oe_all);
        run_cycle(3'h3);
        check("driven again", 8'h00, oe_all);
        check("select io", 8'h01, {7'h00, sel});
        $display("test hold done");
    endtask

    task automatic t_reset();
        @(negedge core_clk);
        req_valid = 1'b1;
        req_kind = 3'h0;
        while (addr_latch_strobe !== 1'b1) @(negedge core_clk);
        req_valid = 1'b0;
        reset_pin = 1'b1; // held ten clocks
        n = 8'h00;
        repeat (10) begin
            @(negedge core_clk);
            if (cycle_done !== 1'b0) n++;
        end
        check("done after abort", 8'h00, n);
        check("enable idle", 8'h01, {7'h00, transceiver_output_enable_n});
        check("core in reset", 8'h01, {7'h00, core_in_reset});
        reset_pin = 1'b0;
        n = 8'h00;
        repeat (8) begin
            @(negedge core_clk);
            if (restart !== 1'b0) n++;
        end
        check("restart", 8'h01, n);
        check("reset released", 8'h00, {7'h00, core_in_reset});
        run_cycle(3'h0);
        check("latency after", 8'h0B, lat);
        $display("test reset done");
    endtask

    task automatic t_strap();
        min_max_mode_strap = 1'b0;
        repeat (3) @(negedge core_clk);
        check("max mode float", 8'h0F, oe_all);
        min_max_mode_strap = 1'b1;
        repeat (3) @(negedge core_clk);
        check("min mode drive", 8'h00, oe_all);
        $display("test strap done");
    endtask

    initial begin
        rst_b = 1'b0;
        reset_pin = 1'b0;
        nmi_pin = 1'b0;
        hold_request = 1'b0;
        min_max_mode_strap = 1'b1;
        req_valid = 1'b0;
        req_kind = 3'h0;
        instr_done = 1'b0;
        stall_cycles = 4'h0;
        mismatches = 0;
        check_count = 0;
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge core_clk);
        t_kinds();
        t_nmi();
        t_hold();
        t_reset();
        t_strap();
        complete_run();
    end
endmodule // tb

bind cpu_min_mode_bus_control bus_ctl_sva bus_ctl_sva_inst (
    .core_clk, .rst_b, .instr_done, .cycle_done, .nmi_take, .nmi_vector_type,
    .restart, .core_in_reset, .hold_grant, .addr_latch_strobe, .io_mem_select,
    .io_mem_select_oe_n, .write_strobe_n, .write_strobe_oe_n,
    .interrupt_ack_strobe_n, .transfer_direction, .transfer_direction_oe_n,
    .transceiver_output_enable_n, .transceiver_output_enable_oe_n
);
`default_nettype wire
